// *** video_dac_pixel_input_stage.sv ***
// pixel and control capture stage feeding three colour converters
`timescale 1ns/1ps
module video_dac_pixel_input_stage (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [dac_in_pkg::COLOR_W-1:0] i_red_word,
   input wire logic [dac_in_pkg::COLOR_W-1:0] i_green_word,
   input wire logic [dac_in_pkg::COLOR_W-1:0] i_blue_word,
   input wire logic i_blank_n,
   input wire logic i_sync_n,
   input wire logic i_low_power_ctl,
   output logic [dac_in_pkg::COLOR_W-1:0] o_red_current_out,
   output logic [dac_in_pkg::COLOR_W-1:0] o_green_current_out,
   output logic [dac_in_pkg::COLOR_W-1:0] o_blue_current_out,
   output logic o_green_sync_on,
   output logic o_low_power,
   output logic o_overflow
);
   import dac_in_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // capture: all inputs on one edge; colour words, blank and sync packed in one word
   pix_stream_if cap ();
   logic [WORD_W-1:0] cap_r;
   logic cap_v_r;
   logic ps_r;
   logic ovf_r;
   // bit zero of each colour word lands at the low end of its field
   wire [WORD_W-1:0] cap_nxt = {i_blue_word, i_green_word, i_red_word,
                                i_sync_n, i_blank_n};

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cap_r <= '0;
         cap_v_r <= 1'b0;
         ps_r <= 1'b0;
      end else begin
         cap_r <= cap_nxt;
         cap_v_r <= 1'b1;
         ps_r <= i_low_power_ctl;
      end
   end
   assign cap.valid = cap_v_r;
   assign cap.data = cap_r;

   ////////////////////////////////////////////////////////////////////////
   // buffer in the data path; drained every cycle unless in power save
   logic fifo_v;
   logic [WORD_W-1:0] fifo_d;
   wire drain = !ps_r;
   pix_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .wr(cap),
      .i_rd_ready(drain),
      .o_rd_valid(fifo_v),
      .o_rd_data(fifo_d)
   );

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) ovf_r <= 1'b0;
      else if (cap.valid && !cap.ready) ovf_r <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // output forming
   wire f_blank_n = fifo_d[BLANK_BIT];
   wire f_sync_n = fifo_d[SYNC_BIT];
   wire [COLOR_W-1:0] f_red = fifo_d[RED_LSB +: COLOR_W];
   wire [COLOR_W-1:0] f_green = fifo_d[GREEN_LSB +: COLOR_W];
   wire [COLOR_W-1:0] f_blue = fifo_d[BLUE_LSB +: COLOR_W];
   wire take = fifo_v && drain;
   wire [COLOR_W-1:0] red_nxt = f_blank_n ? f_red : BLANK_CODE;
   wire [COLOR_W-1:0] green_nxt = f_blank_n ? f_green : BLANK_CODE;
   wire [COLOR_W-1:0] blue_nxt = f_blank_n ? f_blue : BLANK_CODE;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_red_current_out <= RESET_CODE;
         o_green_current_out <= RESET_CODE;
         o_blue_current_out <= RESET_CODE;
         o_green_sync_on <= 1'b0;
         o_low_power <= 1'b0;
         o_overflow <= 1'b0;
      end else begin
         if (take) begin
            o_red_current_out <= red_nxt;
            o_green_current_out <= green_nxt;
            o_blue_current_out <= blue_nxt;
            o_green_sync_on <= f_sync_n;
         end
         o_low_power <= ps_r;
         o_overflow <= ovf_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks: capture stage
   a_stage_one: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[BLANK_BIT] == $past(i_blank_n))
      else $error("blank not captured with pixels");
   a_sync_capture: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[SYNC_BIT] == $past(i_sync_n))
      else $error("sync not captured with pixels");
   a_red_capture: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[RED_LSB +: COLOR_W] == $past(i_red_word))
      else $error("red word not captured");
   a_green_capture: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[GREEN_LSB +: COLOR_W] == $past(i_green_word))
      else $error("green word not captured");
   a_blue_capture: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[BLUE_LSB +: COLOR_W] == $past(i_blue_word))
      else $error("blue word not captured");
   a_lsb_order: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[RED_LSB] == $past(i_red_word[0]))
      else $error("red bit order wrong");
   a_green_lsb: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[GREEN_LSB] == $past(i_green_word[0]))
      else $error("green bit order wrong");
   a_blue_lsb: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[BLUE_LSB] == $past(i_blue_word[0]))
      else $error("blue bit order wrong");
   a_red_msb: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap_v_r |-> cap_r[RED_LSB+COLOR_W-1] == $past(i_red_word[COLOR_W-1]))
      else $error("red top bit misplaced");
   a_ovf_set: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      cap.valid && !cap.ready |=> ##1 o_overflow)
      else $error("lost capture not flagged");
   a_ovf_sticky: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_overflow |=> o_overflow)
      else $error("overflow flag cleared");

   ////////////////////////////////////////////////////////////////////////
   // checks: output stage
   a_blank_forces: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take && !f_blank_n |=> o_red_current_out == BLANK_CODE &&
      o_green_current_out == BLANK_CODE && o_blue_current_out == BLANK_CODE)
      else $error("blank did not force blanking level");
   a_data_passes: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take && f_blank_n |=> o_green_current_out == $past(f_green) &&
      o_red_current_out == $past(f_red) &&
      o_blue_current_out == $past(f_blue))
      else $error("pixel data not forwarded");
   a_sync_green: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take |=> o_green_sync_on == $past(f_sync_n))
      else $error("sync source wrong");
   a_sync_level: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take && !f_blank_n && !f_sync_n |=> !o_green_sync_on &&
      o_green_current_out == BLANK_CODE)
      else $error("sync level wrong");
   a_blue_ignored: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take && !f_blank_n |=> o_blue_current_out == BLANK_CODE)
      else $error("blue input not ignored");
   a_green_ignored: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take && !f_blank_n |=> o_green_current_out == BLANK_CODE)
      else $error("green input not ignored");
   a_red_ignored: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take && !f_blank_n |=> o_red_current_out == BLANK_CODE)
      else $error("red input not ignored");
   a_fixed_lat: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take |=> o_red_current_out == $past(red_nxt))
      else $error("red output latency wrong");
   a_lat_green: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take |=> o_green_current_out == $past(green_nxt))
      else $error("green output latency wrong");
   a_lat_blue: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      take |=> o_blue_current_out == $past(blue_nxt))
      else $error("blue output latency wrong");
   a_out_hold: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      !take |=> $stable(o_red_current_out) &&
      $stable(o_green_current_out) && $stable(o_blue_current_out) &&
      $stable(o_green_sync_on))
      else $error("outputs moved without a word");
   a_drain_stop: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      ps_r && fifo_v |=> fifo_v && $stable(fifo_d))
      else $error("buffer drained in power save");
   a_power_save: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      i_low_power_ctl |=> ##1 o_low_power)
      else $error("power save not entered");
   a_power_exit: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      !i_low_power_ctl |=> ##1 !o_low_power)
      else $error("power save not left");
   a_reset_outs: assert property (
      @(posedge i_mclk)
      i_sys_rst |=> o_red_current_out == RESET_CODE &&
      o_green_current_out == RESET_CODE &&
      o_blue_current_out == RESET_CODE && !o_overflow)
      else $error("outputs not cleared by reset");
endmodule // video_dac_pixel_input_stage

// *** dac_in_pkg.sv ***
// constants shared by the pixel input stage and its buffer
package dac_in_pkg;
   localparam int COLOR_W = 8;
   localparam int WORD_W = 3 * COLOR_W + 2;
   localparam int FIFO_DEPTH = 32;
   localparam int PIPE_LATENCY = 1;
   localparam logic [COLOR_W-1:0] BLANK_CODE = 8'h00;
   localparam logic [COLOR_W-1:0] RESET_CODE = 8'h00;
   localparam int BLANK_BIT = 0;
   localparam int SYNC_BIT = 1;
   localparam int RED_LSB = 2;
   localparam int GREEN_LSB = 10;
   localparam int BLUE_LSB = 18;
endpackage

// *** pix_stream_if.sv ***
// stream carrier between capture stage and buffer
`timescale 1ns/1ps
interface pix_stream_if;
   import dac_in_pkg::*;
   logic valid;
   logic ready;
   logic [WORD_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** pix_fifo.sv ***
// parameterised synchronous fifo with registered read data
`timescale 1ns/1ps
module pix_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   pix_stream_if.snk wr,
   input wire logic i_rd_ready,
   output logic o_rd_valid,
   output logic [WIDTH-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   wire empty = (wp_r == rp_r);
   wire do_wr = wr.valid && !full;
   wire out_free = !o_rd_valid || i_rd_ready;
   wire do_rd = !empty && out_free;
   assign wr.ready = !full;
   always_ff @(posedge i_mclk) begin
      if (do_wr) mem[wp_r[AW-1:0]] <= wr.data;
      if (do_rd) o_rd_data <= mem[rp_r[AW-1:0]];
   end
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wp_r <= '0;
         rp_r <= '0;
         o_rd_valid <= 1'b0;
      end else begin
         if (do_wr) wp_r <= wp_r + 1'b1;
         if (do_rd) rp_r <= rp_r + 1'b1;
         if (out_free) o_rd_valid <= do_rd;
      end
   end
endmodule // pix_fifo

// *** pix_src.sv ***
// behavioural pixel source standing in for the display controller
`timescale 1ns/1ps
module pix_src (
   input wire logic i_mclk,
   output logic [7:0] o_red,
   output logic [7:0] o_green,
   output logic [7:0] o_blue,
   output logic o_blank_n,
   output logic o_sync_n
);
   initial begin
      {o_red, o_green, o_blue} = 24'h000000;
      o_blank_n = 1'b0;
      o_sync_n = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // word is {red, green, blue, blank_n, sync_n}, driven on the falling edge
   task automatic send(input logic [25:0] w);
      @(negedge i_mclk);
      {o_red, o_green, o_blue, o_blank_n} = w[25:1];
      // sync only inside blanking
      o_sync_n = w[1] ? 1'b1 : w[0];
   endtask
endmodule // pix_src

// *** tb.sv ***
// self-checking bench for the pixel input stage
`timescale 1ns/1ps
module tb;
   import dac_in_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic lp = 1'b0;
   logic wen = 1'b0;
   logic flush = 1'b0;
   logic [7:0] r, g, b, ro, go, bo;
   logic bl_n, sy_n, sync_on, low_pw, ovf;
   logic [24:0] q[$];
   logic [24:0] e, o, hold;
   logic [25:0] w;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   assign o = {ro, go, bo, sync_on};
   initial begin
      forever #50 clk = ~clk;
   end
   pix_src drv (.i_mclk(clk), .o_red(r), .o_green(g), .o_blue(b),
      .o_blank_n(bl_n), .o_sync_n(sy_n));
   video_dac_pixel_input_stage DUT (.i_mclk(clk), .i_sys_rst(rst),
      .i_red_word(r), .i_green_word(g), .i_blue_word(b),
      .i_blank_n(bl_n), .i_sync_n(sy_n), .i_low_power_ctl(lp),
      .o_red_current_out(ro), .o_green_current_out(go),
      .o_blue_current_out(bo), .o_green_sync_on(sync_on),
      .o_low_power(low_pw), .o_overflow(ovf));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [24:0] x, input logic [24:0] y);
      checked++;
      if (x !== y) begin
         err_count++;
         $display("unexpected at %0t: exp %h got %h", $time, x, y);
      end
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watcher: a word reaches the outputs four edges after it is driven
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         test_done();
      end
      #1;
      if (wen && (q.size() >= 4 || (flush && q.size() > 0))) begin
         e = q.pop_front();
         chk(e, o);
      end
   end
   initial begin
      void'($urandom(32'hB209));
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(posedge clk);
      #1;
      chk(25'h0000000, o);
      wen = 1'b1;
      for (int i = 0; i < 200; i++) begin
         w = 26'($urandom);
         drv.send(w);
         q.push_back({w[1] ? w[25:2] : {3{BLANK_CODE}}, w[1] | w[0]});
      end
      flush = 1'b1;
      wait (q.size() == 0);
      chk(25'h0000000, {24'h000000, ovf});
      // power save stalls the drain until the buffer refuses
      @(negedge clk);
      wen = 1'b0;
      lp = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(25'h0000001, {24'h000000, low_pw});
      hold = o;
      for (int i = 0; i < 40; i++) drv.send(26'($urandom));
      chk(hold, o);
      chk(25'h0000001, {24'h000000, ovf});
      lp = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      chk(25'h0000000, {ro, go, bo, ovf});
      test_done();
   end
endmodule // tb
